// ---- logic/ncfg_pkg.sv ----
package ncfg_pkg;
   // ------------------------------------------------------------
   // register indices (byte address = 4 * index)
   // ------------------------------------------------------------
   localparam logic [7:0] REG_CD_PHASE = 8'h13;
   localparam logic [7:0] REG_AB_FLO = 8'h14;
   localparam logic [7:0] REG_AB_FHI = 8'h15;
   localparam logic [7:0] REG_CD_FLO = 8'h16;
   localparam logic [7:0] REG_CD_FHI = 8'h17;
   localparam logic [7:0] REG_SYNTH = 8'h18;
   localparam logic [7:0] REG_AUTOSYNC = 8'h1f;
   // ------------------------------------------------------------
   // synth_control_status fields
   // ------------------------------------------------------------
   localparam int LF_DISCHARGE_BIT = 12;
   localparam int DIV_SYNC_BIT = 11;
   localparam int PLL_EN_BIT = 10;
   localparam int CP_LSB = 6;
   localparam int PRE_LSB = 3;
   localparam logic [15:0] SYNTH_RESET = 16'h2808;
   localparam logic [15:0] SYNTH_RSVD_MASK = 16'he300;
   localparam logic [15:0] SYNTH_RW_MASK = 16'h1cf8;
   localparam int AUTOSYNC_CD_BIT = 0;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   // ------------------------------------------------------------
   // charge pump decode
   // ------------------------------------------------------------
   localparam logic [1:0] CP_NONE = 2'h0;
   localparam logic [1:0] CP_SINGLE = 2'h1;
   localparam logic [1:0] CP_DUAL = 2'h3;
endpackage

// ---- logic/ncfg_cp_decode.sv ----
`timescale 1ns/10ps
// charge pump and prescaler decode
module ncfg_cp_decode (
   input wire logic [1:0] cp_code_in,
   input wire logic [2:0] pre_code_in,
   output logic [1:0] pump_count_out,
   output logic [3:0] pre_div_out
);
   import ncfg_pkg::*;
   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   always_comb begin
      unique case (cp_code_in)
         CP_SINGLE: pump_count_out = 2'h1;
         CP_DUAL: pump_count_out = 2'h2;
         default: pump_count_out = 2'h0; // none or unused code
      endcase
      // code 000 selects 8, 001 unused maps to 8 as well
      if (pre_code_in < 3'h2) begin
         pre_div_out = 4'h8;
      end else begin
         pre_div_out = {1'b0, pre_code_in};
      end
   end
endmodule

// ---- logic/ncfg_phase_addr.sv ----
`timescale 1ns/10ps
// phase offset addition for the sine/cosine table address
module ncfg_phase_addr (
   input wire logic [31:0] acc_in,
   input wire logic [15:0] offset_in,
   output logic [15:0] addr_out
);
   // ------------------------------------------------------------
   // upper accumulator half plus offset, wraps modulo 2^16
   // ------------------------------------------------------------
   assign addr_out = 16'(acc_in[31:16] + offset_in);
endmodule

// ---- logic/ncfg_regs.sv ----
// Our own choice: register access over APB.
`timescale 1ns/10ps
module ncfg_regs (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   input wire logic [2:0] lf_volt_in,
   input wire logic lvds_sync_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic [15:0] cd_table_addr_out,
   output logic [31:0] ab_pair_freq_word_out,
   output logic [31:0] cd_pair_freq_word_out,
   output logic [15:0] cd_pair_phase_offset_out,
   output logic autosync_pulse_out,
   output logic lf_discharge_out,
   output logic pll_enable_out,
   output logic pll_bypass_out,
   output logic ndiv_sync_out,
   output logic [1:0] pump_count_out,
   output logic [3:0] pre_div_out
);
   import ncfg_pkg::*;

   typedef struct packed {
      logic [15:0] cd_phase;
      logic [15:0] ab_flo;
      logic [15:0] ab_fhi;
      logic [15:0] cd_flo;
      logic [15:0] cd_fhi;
      logic [15:0] synth;
      logic autosync_en;
      logic [31:0] ab_act;
      logic [31:0] cd_act;
      logic [15:0] cd_phase_act;
      logic [31:0] cd_acc;
      logic [15:0] table_addr;
      logic sync_pulse;
      logic [2:0] lf_volt;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic [1:0] pumps;
      logic [3:0] prediv;
      logic ndiv_sync;
      logic bypass;
   } ncfg_state_s;

   ncfg_state_s cur;
   ncfg_state_s next_cur;
   logic [15:0] sum_addr;
   logic [1:0] dec_pumps;
   logic [3:0] dec_prediv;
   logic [7:0] idx;
   logic setup;
   logic access;
   logic wr;
   logic rd;
   logic [15:0] wdata;
   logic [15:0] synth_view;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   ncfg_phase_addr u_phase (
      .acc_in(cur.cd_acc),
      .offset_in(cur.cd_phase_act),
      .addr_out(sum_addr)
   );

   ncfg_cp_decode u_dec (
      .cp_code_in(cur.synth[CP_LSB+1:CP_LSB]),
      .pre_code_in(cur.synth[PRE_LSB+2:PRE_LSB]),
      .pump_count_out(dec_pumps),
      .pre_div_out(dec_prediv)
   );

   // bus decode: word index from byte address; answer in the first access cycle
   // addresses above the word window decode as an unmapped index
   assign idx = (paddr_in[11:10] == 2'h0) ? paddr_in[9:2] : 8'hff;
   assign setup = psel_in && !penable_in;
   // writes land at the access edge that samples pready high, never earlier
   assign access = psel_in && penable_in && cur.ready;
   assign wr = access && pwrite_in && (paddr_in[1:0] == 2'h0);
   assign rd = setup && !pwrite_in;
   assign wdata = {pstrb_in[1] ? pwdata_in[15:8] : 8'h00, pstrb_in[0] ? pwdata_in[7:0] : 8'h00};
   // readback: reserved bits at reset value, indicator live
   assign synth_view = (cur.synth & SYNTH_RW_MASK) | (SYNTH_RESET & SYNTH_RSVD_MASK)
      | {13'h0000, cur.lf_volt};

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_cur = cur;
      next_cur.sync_pulse = 1'b0;
      next_cur.ready = 1'b0;
      next_cur.err = 1'b0;
      next_cur.lf_volt = lf_volt_in;
      next_cur.table_addr = sum_addr;
      next_cur.pumps = dec_pumps;
      next_cur.prediv = dec_prediv;
      next_cur.ndiv_sync = cur.synth[DIV_SYNC_BIT] && lvds_sync_in;
      // signed step: adding a negative word wraps the phase backwards
      next_cur.cd_acc = 32'(cur.cd_acc + cur.cd_act);
      // response decided in the setup cycle: unmapped index or misaligned write errors
      if (setup) begin
         next_cur.ready = 1'b1;
         unique case (idx)
            REG_CD_PHASE, REG_AB_FLO, REG_AB_FHI, REG_CD_FLO, REG_CD_FHI, REG_SYNTH,
            REG_AUTOSYNC: next_cur.err = pwrite_in && (paddr_in[1:0] != 2'h0);
            default: next_cur.err = 1'b1;
         endcase
      end
      if (wr) begin
         unique case (idx)
            REG_CD_PHASE: begin
               next_cur.cd_phase = wdata;
               if (cur.autosync_en) begin
                  next_cur.sync_pulse = 1'b1;
                  next_cur.cd_phase_act = wdata;
                  next_cur.cd_act = {cur.cd_fhi, cur.cd_flo};
               end
            end
            REG_AB_FLO: begin
               next_cur.ab_flo = wdata;
               next_cur.ab_act = {cur.ab_fhi, wdata};
            end
            REG_AB_FHI: begin
               next_cur.ab_fhi = wdata;
               next_cur.ab_act = {wdata, cur.ab_flo};
            end
            REG_CD_FLO: next_cur.cd_flo = wdata; // staged only
            REG_CD_FHI: next_cur.cd_fhi = wdata; // staged only
            REG_SYNTH: begin
               next_cur.synth = (wdata & SYNTH_RW_MASK) | (SYNTH_RESET & ~SYNTH_RW_MASK);
            end
            REG_AUTOSYNC: next_cur.autosync_en = wdata[AUTOSYNC_CD_BIT];
            default: next_cur.sync_pulse = 1'b0; // unmapped: write dropped
         endcase
      end
      // bypass has its own flop so the output comes straight from a register
      next_cur.bypass = !next_cur.synth[PLL_EN_BIT];
      if (rd) begin
         unique case (idx)
            REG_CD_PHASE: next_cur.rdata = {16'h0000, cur.cd_phase};
            REG_AB_FLO: next_cur.rdata = {16'h0000, cur.ab_flo};
            REG_AB_FHI: next_cur.rdata = {16'h0000, cur.ab_fhi};
            REG_CD_FLO: next_cur.rdata = {16'h0000, cur.cd_flo};
            REG_CD_FHI: next_cur.rdata = {16'h0000, cur.cd_fhi};
            REG_SYNTH: next_cur.rdata = {16'h0000, synth_view};
            REG_AUTOSYNC: next_cur.rdata = {31'h00000000, cur.autosync_en};
            default: next_cur.rdata = 32'h00000000; // unmapped reads as zero
         endcase
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         cur <= '0;
         cur.synth <= SYNTH_RESET;
         cur.bypass <= 1'b1;
      end else begin
         cur <= next_cur;
      end
   end

   // ------------------------------------------------------------
   // outputs, all from flip-flops
   // ------------------------------------------------------------
   assign prdata_out = cur.rdata;
   assign pready_out = cur.ready;
   assign pslverr_out = cur.err;
   assign cd_table_addr_out = cur.table_addr;
   assign ab_pair_freq_word_out = cur.ab_act;
   assign cd_pair_freq_word_out = cur.cd_act;
   assign cd_pair_phase_offset_out = cur.cd_phase_act;
   assign autosync_pulse_out = cur.sync_pulse;
   assign lf_discharge_out = cur.synth[LF_DISCHARGE_BIT];
   assign pll_enable_out = cur.synth[PLL_EN_BIT];
   assign pll_bypass_out = cur.bypass;
   assign ndiv_sync_out = cur.ndiv_sync;
   assign pump_count_out = cur.pumps;
   assign pre_div_out = cur.prediv;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   // a full-strobe phase offset write completing at its access edge
   sequence phase_write_s;
      psel_in && penable_in && pready_out && pwrite_in && paddr_in == 12'h04c
         && pstrb_in == 4'hf;
   endsequence

   property autosync_p;
      @(posedge clk_in) disable iff (!rstn_in)
      phase_write_s and cur.autosync_en |=> autosync_pulse_out
         && cd_pair_phase_offset_out == $past(pwdata_in[15:0]);
   endproperty

   autosync_fire_a: assert property (autosync_p) else $error("auto-sync missing");
   sync_gate_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      autosync_pulse_out |-> $past(cur.autosync_en))
      else $error("auto-sync while disabled");
   freq_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      !autosync_pulse_out |-> $stable(cd_pair_freq_word_out))
      else $error("cd word changed without auto-sync");
   sync_load_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      autosync_pulse_out |-> cd_pair_freq_word_out == $past({cur.cd_fhi, cur.cd_flo}))
      else $error("cd word not loaded");
   table_addr_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      cd_table_addr_out == 16'($past(cur.cd_acc[31:16] + cur.cd_phase_act)))
      else $error("table address wrong");
   acc_step_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      cur.cd_acc == 32'($past(cur.cd_acc) + $past(cur.cd_act)))
      else $error("accumulator step wrong");
   bypass_pair_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      pll_bypass_out == !pll_enable_out) else $error("bypass mismatch");
   pump_code_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      cur.synth[7:6] == 2'h3 ##1 cur.synth[7:6] == 2'h3 |-> pump_count_out == 2'h2)
      else $error("dual pump decode");
   prediv_code_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      cur.synth[5:3] == 3'h0 ##1 cur.synth[5:3] == 3'h0 |-> pre_div_out == 4'h8)
      else $error("prescaler 8 decode");
   rsvd_read_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      $past(rd && idx == REG_SYNTH) |-> prdata_out[15:13] == 3'h1 && prdata_out[9:8] == 2'h0)
      else $error("reserved bits wrong");
   synth_mask_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (cur.synth & ~SYNTH_RW_MASK) == (SYNTH_RESET & ~SYNTH_RW_MASK))
      else $error("read-only synth bits written");
   ndiv_gate_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      ndiv_sync_out |-> $past(cur.synth[11] && lvds_sync_in))
      else $error("divider sync ungated");
   discharge_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      wr && idx == REG_SYNTH |=> lf_discharge_out == $past(wdata[LF_DISCHARGE_BIT]))
      else $error("discharge bit not applied");
   lfvolt_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      $past(rd && idx == REG_SYNTH) |-> prdata_out[2:0] == $past(cur.lf_volt))
      else $error("indicator readback wrong");
   // bus response shape: one-cycle ready, error only alongside ready
   ready_pulse_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      pready_out |=> !pready_out) else $error("ready longer than one cycle");
   err_ready_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      pslverr_out |-> pready_out) else $error("error without ready");
endmodule

// ---- sim/test_nco_pll_config_registers.sv ----
`timescale 1ns/10ps
module test_nco_pll_config_registers;
   import ncfg_pkg::*;
   logic clk_in, rstn_in, psel_in, penable_in, pwrite_in, lvds_sync_in, rdy, err, sp, dis, en, byp;
   logic nds;
   logic [11:0] paddr_in;
   logic [31:0] pwdata_in, prdata, ab_o, cd_o, ab_w, cd_w;
   logic [2:0] lf_volt_in;
   logic [15:0] cd_off, cd_tab, w, p;
   logic [1:0] pump;
   logic [3:0] pre;
   logic [33:0] notes[$];
   logic [33:0] note;
   int miscompares = 0, n_compared = 0, n_sync = 0, seed = 97, k;

   ncfg_regs dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .pstrb_in(4'hf), .lf_volt_in(lf_volt_in),
      .lvds_sync_in(lvds_sync_in), .prdata_out(prdata), .pready_out(rdy), .pslverr_out(err),
      .cd_table_addr_out(cd_tab), .ab_pair_freq_word_out(ab_o), .cd_pair_freq_word_out(cd_o),
      .cd_pair_phase_offset_out(cd_off), .autosync_pulse_out(sp), .lf_discharge_out(dis),
      .pll_enable_out(en), .pll_bypass_out(byp), .ndiv_sync_out(nds), .pump_count_out(pump),
      .pre_div_out(pre));

   // ----------------------------------------------------------------
   // compare, verdict and bus tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      if (miscompares == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // one apb transfer; the note is what the monitor expects at pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [33:0] nt);
      int j;
      @(posedge clk_in);
      notes.push_back(nt);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      for (j = 0; j < 20; j++) begin
         @(posedge clk_in);
         if (rdy === 1'b1) break;
      end
      if (j == 20) begin
         miscompares++;
         close_out();
      end
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic e);
      apb(1'b1, a, {16'h0000, d}, {1'b0, e, 32'h0000_0000});
   endtask

   task automatic rd(input logic [11:0] a, input logic [15:0] d, input logic e);
      apb(1'b0, a, 32'h0000_0000, {1'b1, e, 16'h0000, d});
   endtask

   task automatic settle();
      repeat (2) @(negedge clk_in);
   endtask

   // monitor: oldest note against each completed transfer
   always @(posedge clk_in) begin
      if (sp === 1'b1) n_sync++;
      if (psel_in && penable_in && rdy === 1'b1 && notes.size() > 0) begin
         note = notes.pop_front();
         if (note[33]) check({err, prdata}, note[32:0]);
         else check({err, 32'h0000_0000}, {note[32], 32'h0000_0000});
      end
   end

   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rstn_in = 1'b0;
      {psel_in, penable_in, pwrite_in, lvds_sync_in} = 4'h0;
      paddr_in = 12'h000;
      pwdata_in = 32'h0000_0000;
      lf_volt_in = 3'h5;
      repeat (16) @(posedge clk_in);
      rstn_in <= 1'b1;
      settle();
      check({byp, en, dis, nds, pump, pre}, {4'h8, 2'h0, 4'h8});
      for (k = 0; k < 5; k++) rd(12'h04c + 12'(4 * k), 16'h0000, 1'b0);
      rd(12'h060, SYNTH_RESET | 16'h0005, 1'b0);
      // tune: step the indicator up until it sits in the 010..101 lock window
      for (k = 0; k < 8; k++) begin
         lf_volt_in <= 3'(k);
         rd(12'h060, SYNTH_RESET | 16'(k), 1'b0);
         if (3'(k) >= 3'h2 && 3'(k) <= 3'h5) break;
      end
      ab_w = $random(seed);
      cd_w = $random(seed) | 32'h8000_0000;
      wr(12'h050, ab_w[15:0], 1'b0);
      wr(12'h054, ab_w[31:16], 1'b0);
      settle();
      check(ab_o, ab_w);
      wr(12'h058, cd_w[15:0], 1'b0);
      wr(12'h05c, cd_w[31:16], 1'b0);
      rd(12'h05c, cd_w[31:16], 1'b0);
      p = $random(seed);
      wr(12'h04c, p, 1'b0);
      settle();
      check({n_sync[0], cd_o}, 33'h0);
      wr(12'h07c, 16'h0001, 1'b0);
      wr(12'h04c, ~p, 1'b0);
      settle();
      check({n_sync[1:0], cd_off}, {2'h1, ~p});
      check(cd_o, cd_w);
      rd(12'h0f0, 16'h0000, 1'b1);
      wr(12'h052, 16'h1234, 1'b1);
      settle();
      check(ab_o, ab_w);
      // upper-half step of one: the table address counts up by one each cycle
      wr(12'h058, 16'h0000, 1'b0);
      wr(12'h05c, 16'h0001, 1'b0);
      wr(12'h04c, p, 1'b0);
      settle();
      w = cd_tab;
      @(negedge clk_in);
      check(cd_tab, 16'(w + 16'h0001));
      // all-ones upper half is minus one step: the address counts down
      wr(12'h05c, 16'hffff, 1'b0);
      wr(12'h04c, p, 1'b0);
      settle();
      w = cd_tab;
      @(negedge clk_in);
      check(cd_tab, 16'(w - 16'h0001));
      // frozen accumulator: the address moves by exactly the offset change
      wr(12'h05c, 16'h0000, 1'b0);
      wr(12'h04c, p, 1'b0);
      settle();
      w = cd_tab;
      wr(12'h04c, 16'(p + cd_w[15:0]), 1'b0);
      settle();
      check(cd_tab, 16'(w + cd_w[15:0]));
      for (k = 0; k < 32; k++) begin
         @(posedge clk_in);
         lvds_sync_in <= k[1] ^ k[3];
         lf_volt_in <= 3'($random(seed));
         w = 16'($random(seed));
         w[7:3] = {k[1:0], k[4:2]};
         wr(12'h060, w, 1'b0);
         settle();
         check({dis, en, byp, nds}, {w[12], w[10], ~w[10], w[11] & lvds_sync_in});
         check(pump, (w[7:6] == 2'h1) ? 2'h1 : (w[7:6] == 2'h3) ? 2'h2 : 2'h0);
         check(pre, (w[5:3] < 3'h2) ? 4'h8 : {1'b0, w[5:3]});
         rd(12'h060, (w & SYNTH_RW_MASK) | 16'h2000 | {13'h0, lf_volt_in}, 1'b0);
      end
      settle();
      if (notes.size() != 0) miscompares++;
      close_out();
   end
endmodule
